// *** rtl/mcr_defines.svh ***
// Constants for the multicast classify and route block: offsets,
// field positions, reset values and bus wait timing.
// Assumes byte addresses on a 32-bit Avalon-MM slave.
// What this block does
// - Only posted writes, address messages are candidates
// - Global enable clear means nothing is multicast
// - Non-multicast TLPs take the unicast path
// - Group region size is two to index
// - Regions ascend from base; none past count
// - Base address is 64-bit, bits 11:0 always zero
// - Zero low and group bits, compare base
// - Group ID bits from index, ceil log2 of count plus one
// - Group ID above count means not multicast
// - Only source validation check applies to multicast
// - Ingress block-all bit set blocks the TLP
// - Block-untranslated bit plus untranslated AT blocks
// - Blocked TLP dropped, credits still returned
// - Blocked TLP reported to AER, header logged
// - Target abort flag: upstream primary, downstream secondary
// - Offer to all functions except the receiver
// - Function with multicast disabled ignores it
// - Enabled function accepts on receive vector bit
// - No acceptor means silent discard, no error
// - Same routing rules in every function
// - At most 64 groups, limit defaults to 32
`ifndef MCR_DEFINES_SVH
`define MCR_DEFINES_SVH

// Global register byte offsets
`define MCR_OFS_CTRL 12'h000
`define MCR_OFS_CAP 12'h004
`define MCR_OFS_BASE_LO 12'h008
`define MCR_OFS_BASE_HI 12'h00c
`define MCR_OFS_LOG_LO 12'h010
`define MCR_OFS_LOG_HI 12'h014
`define MCR_OFS_LOG_INFO 12'h018
// Per-port block: 0x100 + port * 0x40, register index in bits 5:2
`define MCR_PORT_REGION 4'h1
`define MCR_PREG_FN_CTL 4'h0
`define MCR_PREG_RCV_LO 4'h1
`define MCR_PREG_RCV_HI 4'h2
`define MCR_PREG_BLKALL_LO 4'h3
`define MCR_PREG_BLKALL_HI 4'h4
`define MCR_PREG_BLKUT_LO 4'h5
`define MCR_PREG_BLKUT_HI 4'h6
`define MCR_PREG_STATUS 4'h7

// Field positions
`define MCR_CTRL_EN_BIT 0
`define MCR_CTRL_CNT_LSB 8
`define MCR_BASE_IDX_LSB 0
`define MCR_BASE_ADDR_LSB 12
`define MCR_STS_PRI_TA_BIT 0
`define MCR_STS_SEC_TA_BIT 1

// Reset values; limit field 31 advertises 32 groups
`define MCR_CAP_LIMIT_RST 6'h1f
`define MCR_AT_UNTRANSLATED 2'h0
`define MCR_MAX_GROUPS 7'h40
`define MCR_ACK_WAIT_CYCLES 1

`endif

// *** rtl/mcr_pkg.sv ***
// Types shared by the multicast classify and route block.
// Assumes the defines header supplies all numeric constants.
package mcr_pkg;
   // Kind of received TLP as decoded by the ingress port
   typedef enum logic [1:0] {
      MCR_TLP_MWR,
      MCR_TLP_MSG_ADDR,
      MCR_TLP_OTHER
   } mcr_tlp_kind_t;
endpackage

// *** rtl/mcr_egress_slot.sv ***
// One-entry hand-off to a function's egress processing stage.
// Assumes the egress stage drains by valid and ready on clk.
`timescale 1ns/1ps
module mcr_egress_slot #(
   parameter int TAG_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Load side
   input wire logic load,
   input wire logic [5:0] load_gid,
   input wire logic [63:0] load_addr,
   input wire logic [TAG_W-1:0] load_tag,
   output logic slot_ready,
   // Egress side
   output logic eg_valid,
   input wire logic eg_ready,
   output logic [5:0] eg_gid,
   output logic [63:0] eg_addr,
   output logic [TAG_W-1:0] eg_tag
);
   logic valid_r;
   logic [5:0] gid_r;
   logic [63:0] addr_r;
   logic [TAG_W-1:0] tag_r;

   // Room whenever empty or draining this cycle
   assign slot_ready = !valid_r || eg_ready;
   assign eg_valid = valid_r;
   assign eg_gid = gid_r;
   assign eg_addr = addr_r;
   assign eg_tag = tag_r;

   // Hold the accepted TLP with its group until taken
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         valid_r <= 1'b0;
         gid_r <= 6'h00;
         addr_r <= 64'h0;
         tag_r <= '0;
      end else if (load) begin
         valid_r <= 1'b1;
         gid_r <= load_gid;
         addr_r <= load_addr;
         tag_r <= load_tag;
      end else if (eg_ready) begin
         valid_r <= 1'b0;
      end
   end

   property p_slot_hold;
      @(posedge clk) disable iff (!reset_n)
      eg_valid && !eg_ready |=> eg_valid && $stable(eg_addr);
   endproperty
   a_slot_hold: assert property (p_slot_hold)
      else $error("egress slot dropped or changed a waiting TLP");
endmodule

// *** rtl/mcr_route.sv ***
// Multicast classification, ingress blocking and virtual-bus routing.
// Assumes one TLP header per cycle from ingress and Avalon-MM access.
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "mcr_defines.svh"
module mcr_route #(
   parameter int NPORTS = 4,
   parameter int TAG_W = 8,
   parameter int PW = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Avalon-MM register slave
   input wire logic [11:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Ingress TLP headers
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [PW-1:0] in_port,
   input wire mcr_pkg::mcr_tlp_kind_t in_kind,
   input wire logic [63:0] in_addr,
   input wire logic [1:0] in_at,
   input wire logic [TAG_W-1:0] in_tag,
   input wire logic in_srcval_fail,
   // Unicast path
   output logic uc_valid,
   input wire logic uc_ready,
   output logic [PW-1:0] uc_port,
   output logic [63:0] uc_addr,
   output logic [TAG_W-1:0] uc_tag,
   // Per-function egress stage
   output logic [NPORTS-1:0] eg_valid,
   input wire logic [NPORTS-1:0] eg_ready,
   output logic [NPORTS*6-1:0] eg_gid,
   output logic [NPORTS*64-1:0] eg_addr,
   output logic [NPORTS*TAG_W-1:0] eg_tag,
   // Events, one cycle each
   output logic credit_return,
   output logic aer_mc_blocked,
   output logic acs_src_violation,
   output logic mc_silent_discard
);
   import mcr_pkg::*;
   // All checks below sample on clk and pause in reset
   default clocking mcr_cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Global configuration
   logic multicast_global_enable_r;
   logic [5:0] enabled_group_count_r, supported_group_limit_r;
   logic [5:0] group_index_position_r;
   logic [63:0] base_r, log_addr_r;
   logic [PW+5:0] log_info_r;
   // Per-function configuration and status
   logic [NPORTS-1:0] function_multicast_enable_r;
   logic [63:0] group_receive_vector_r [NPORTS];
   logic [63:0] group_block_all_bits_r [NPORTS];
   logic [63:0] group_block_untranslated_bits_r [NPORTS];
   logic [NPORTS-1:0] pri_ta_r, sec_ta_r;
   // Bus handshake and read mux
   logic ack_r;
   logic [31:0] rd_r, rd_mux;
   // Event pulses and unicast hand-off register
   logic credit_r, aer_r, acs_r, silent_r;
   logic uc_valid_r;
   logic [PW-1:0] uc_port_r;
   logic [63:0] uc_addr_r;
   logic [TAG_W-1:0] uc_tag_r;

   // Bits needed to number enabled_group_count+1 groups
   function automatic logic [2:0] mcr_gbits(input logic [5:0] cnt);
      logic [2:0] b;
      b = 3'd0;
      for (int i = 6; i >= 0; i--) begin
         if ((7'd1 << i) >= ({1'b0, cnt} + 7'd1)) b = 3'(i);
      end
      return b;
   endfunction

   // Bus decode
   wire acc = read || write;
   wire wr_en = write && ack_r;
   wire in_port_region = address[11:8] == `MCR_PORT_REGION;
   wire [PW-1:0] psel = address[PW+5:6];
   wire [3:0] preg = address[5:2];
   wire port_ok = in_port_region && (32'(address[7:6]) < NPORTS);

   // One wait cycle, then answer
   assign waitrequest = acc && !ack_r;
   assign readdata = rd_r;

   // Classification datapath
   wire [2:0] gbits = mcr_gbits(enabled_group_count_r);
   wire [6:0] span = 7'({1'b0, group_index_position_r}) + 7'(gbits);
   wire [63:0] low_mask = (64'h1 << span) - 64'h1;
   wire [63:0] masked_addr = in_addr & ~low_mask;
   wire base_hit = masked_addr == base_r;
   wire [63:0] shifted = in_addr >> group_index_position_r;
   wire [63:0] gmask = (64'h1 << gbits) - 64'h1;
   wire [5:0] gid = 6'(shifted & gmask);
   wire gid_ok = gid <= enabled_group_count_r;
   wire kind_ok = (in_kind == MCR_TLP_MWR)
      || (in_kind == MCR_TLP_MSG_ADDR);
   wire is_mc = multicast_global_enable_r && kind_ok && base_hit
      && gid_ok;
   wire acs_fail = is_mc && in_srcval_fail;
   wire blk_all = group_block_all_bits_r[in_port][gid];
   wire blk_ut = group_block_untranslated_bits_r[in_port][gid]
      && (in_at == `MCR_AT_UNTRANSLATED);
   wire blocked = is_mc && !acs_fail && (blk_all || blk_ut);
   wire mc_ok = is_mc && !acs_fail && !blocked;

   // Same acceptance test in every function, receiver excluded
   logic [NPORTS-1:0] accept, slot_ready;
   always_comb begin
      for (int p = 0; p < NPORTS; p++) begin
         accept[p] = mc_ok && (in_port != PW'(p))
            && function_multicast_enable_r[p]
            && group_receive_vector_r[p][gid];
      end
   end

   // Stall ingress when any egress slot or the unicast output is full
   assign in_ready = (&slot_ready) && (!uc_valid_r || uc_ready);
   wire take = in_valid && in_ready;
   wire to_uc = take && !is_mc;

   // Egress slot per function
   for (genvar g = 0; g < NPORTS; g++) begin : g_slot
      mcr_egress_slot #(.TAG_W(TAG_W)) u_slot (
         .clk(clk),
         .reset_n(reset_n),
         .load(take && accept[g]),
         .load_gid(gid),
         .load_addr(in_addr),
         .load_tag(in_tag),
         .slot_ready(slot_ready[g]),
         .eg_valid(eg_valid[g]),
         .eg_ready(eg_ready[g]),
         .eg_gid(eg_gid[g*6 +: 6]),
         .eg_addr(eg_addr[g*64 +: 64]),
         .eg_tag(eg_tag[g*TAG_W +: TAG_W])
      );
   end

   // Registered hand-off and event outputs
   assign {uc_valid, uc_port, uc_addr, uc_tag} =
      {uc_valid_r, uc_port_r, uc_addr_r, uc_tag_r};
   assign {credit_return, aer_mc_blocked, acs_src_violation,
      mc_silent_discard} = {credit_r, aer_r, acs_r, silent_r};

   // Unicast hand-off register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         uc_valid_r <= 1'b0;
         uc_port_r <= '0;
         uc_addr_r <= 64'h0;
         uc_tag_r <= '0;
      end else if (to_uc) begin
         uc_valid_r <= 1'b1;
         uc_port_r <= in_port;
         uc_addr_r <= in_addr;
         uc_tag_r <= in_tag;
      end else if (uc_ready) begin
         uc_valid_r <= 1'b0;
      end
   end

   // Drop and error pulses; credits flow back for blocked and source-violation drops only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         credit_r <= 1'b0;
         aer_r <= 1'b0;
         acs_r <= 1'b0;
         silent_r <= 1'b0;
      end else begin
         credit_r <= take && (blocked || acs_fail);
         aer_r <= take && blocked;
         acs_r <= take && acs_fail;
         silent_r <= take && mc_ok && (accept == '0);
      end
   end

   // Header log of the last blocked TLP
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         log_addr_r <= 64'h0;
         log_info_r <= '0;
      end else if (take && blocked) begin
         log_addr_r <= in_addr;
         log_info_r <= {in_port, gid};
      end
   end

   // Bus answer: read data latched in the wait cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
         rd_r <= 32'h0;
      end else begin
         ack_r <= acc && !ack_r;
         if (read && !ack_r) rd_r <= rd_mux;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0;
      if (port_ok) begin
         case (preg)
            `MCR_PREG_FN_CTL: rd_mux = {31'h0,
               function_multicast_enable_r[psel]};
            `MCR_PREG_RCV_LO: rd_mux = group_receive_vector_r[psel][31:0];
            `MCR_PREG_RCV_HI: rd_mux = group_receive_vector_r[psel][63:32];
            `MCR_PREG_BLKALL_LO: rd_mux = group_block_all_bits_r[psel][31:0];
            `MCR_PREG_BLKALL_HI: rd_mux = group_block_all_bits_r[psel][63:32];
            `MCR_PREG_BLKUT_LO:
               rd_mux = group_block_untranslated_bits_r[psel][31:0];
            `MCR_PREG_BLKUT_HI:
               rd_mux = group_block_untranslated_bits_r[psel][63:32];
            `MCR_PREG_STATUS: rd_mux = {30'h0, sec_ta_r[psel], pri_ta_r[psel]};
            default: rd_mux = 32'h0;
         endcase
      end else begin
         case (address)
            `MCR_OFS_CTRL: rd_mux = {18'h0, enabled_group_count_r,
               7'h0, multicast_global_enable_r};
            `MCR_OFS_CAP: rd_mux = {26'h0, supported_group_limit_r};
            `MCR_OFS_BASE_LO: rd_mux = {base_r[31:12], 6'h0,
               group_index_position_r};
            `MCR_OFS_BASE_HI: rd_mux = base_r[63:32];
            `MCR_OFS_LOG_LO: rd_mux = log_addr_r[31:0];
            `MCR_OFS_LOG_HI: rd_mux = log_addr_r[63:32];
            `MCR_OFS_LOG_INFO: rd_mux = 32'(log_info_r);
            default: rd_mux = 32'h0;
         endcase
      end
   end

   // Global register writes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         multicast_global_enable_r <= 1'b0;
         enabled_group_count_r <= 6'h00;
         supported_group_limit_r <= `MCR_CAP_LIMIT_RST;
         group_index_position_r <= 6'h00;
         base_r <= 64'h0;
      end else if (wr_en && !in_port_region) begin
         case (address)
            `MCR_OFS_CTRL: begin
               multicast_global_enable_r <= writedata[`MCR_CTRL_EN_BIT];
               enabled_group_count_r <= writedata[`MCR_CTRL_CNT_LSB +: 6];
            end
            `MCR_OFS_CAP: supported_group_limit_r <= writedata[5:0];
            `MCR_OFS_BASE_LO: begin
               group_index_position_r <= writedata[`MCR_BASE_IDX_LSB +: 6];
               base_r[31:12] <= writedata[31:`MCR_BASE_ADDR_LSB];
            end
            `MCR_OFS_BASE_HI: base_r[63:32] <= writedata;
            default: ;
         endcase
      end
   end

   // Per-function writes; set of an abort flag wins over its clear
   wire status_wr = wr_en && port_ok && (preg == `MCR_PREG_STATUS);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         function_multicast_enable_r <= '0;
         pri_ta_r <= '0;
         sec_ta_r <= '0;
         for (int p = 0; p < NPORTS; p++) begin
            group_receive_vector_r[p] <= 64'h0;
            group_block_all_bits_r[p] <= 64'h0;
            group_block_untranslated_bits_r[p] <= 64'h0;
         end
      end else begin
         for (int p = 0; p < NPORTS; p++) begin
            if (status_wr && (psel == PW'(p))) begin
               if (writedata[`MCR_STS_PRI_TA_BIT]) pri_ta_r[p] <= 1'b0;
               if (writedata[`MCR_STS_SEC_TA_BIT]) sec_ta_r[p] <= 1'b0;
            end
            if (take && blocked && (in_port == PW'(p))) begin
               if (p == 0) pri_ta_r[p] <= 1'b1;
               else sec_ta_r[p] <= 1'b1;
            end
         end
         if (wr_en && port_ok) begin
            case (preg)
               `MCR_PREG_FN_CTL:
                  function_multicast_enable_r[psel] <= writedata[0];
               `MCR_PREG_RCV_LO:
                  group_receive_vector_r[psel][31:0] <= writedata;
               `MCR_PREG_RCV_HI:
                  group_receive_vector_r[psel][63:32] <= writedata;
               `MCR_PREG_BLKALL_LO:
                  group_block_all_bits_r[psel][31:0] <= writedata;
               `MCR_PREG_BLKALL_HI:
                  group_block_all_bits_r[psel][63:32] <= writedata;
               `MCR_PREG_BLKUT_LO:
                  group_block_untranslated_bits_r[psel][31:0] <= writedata;
               `MCR_PREG_BLKUT_HI:
                  group_block_untranslated_bits_r[psel][63:32] <= writedata;
               default: ;
            endcase
         end
      end
   end

   // Checks on classification and routing
   property p_kind;
      take && in_kind == MCR_TLP_OTHER |=> uc_valid;
   endproperty
   a_kind: assert property (p_kind)
      else $error("non-candidate TLP missed the unicast path");
   property p_global_off;
      take && !multicast_global_enable_r |=> uc_valid && !aer_mc_blocked;
   endproperty
   a_global_off: assert property (p_global_off)
      else $error("TLP treated as multicast while disabled");
   property p_gid_range;
      take && kind_ok && base_hit && gid > enabled_group_count_r
      |=> uc_valid;
   endproperty
   a_gid_range: assert property (p_gid_range)
      else $error("out-of-range group not sent unicast");
   property p_blocked;
      take && blocked |=> credit_return && aer_mc_blocked
      && log_addr_r == $past(in_addr)
      && eg_valid == $past(eg_valid & ~eg_ready);
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("blocked TLP not dropped with credit and report");
   property p_blk_all;
      take && is_mc && !in_srcval_fail && blk_all |=> aer_mc_blocked;
   endproperty
   a_blk_all: assert property (p_blk_all)
      else $error("block-all bit did not block");
   property p_ta_up;
      take && blocked && in_port == '0 |=> pri_ta_r[0];
   endproperty
   a_ta_up: assert property (p_ta_up)
      else $error("upstream target abort flag not set");
   property p_no_self;
      take && mc_ok |=> !eg_valid[$past(in_port)] || $past(eg_valid[in_port]);
   endproperty
   a_no_self: assert property (p_no_self)
      else $error("receiving function took its own multicast TLP");
   property p_silent;
      mc_silent_discard |-> !aer_mc_blocked && !credit_return;
   endproperty
   a_silent: assert property (p_silent)
      else $error("silent discard raised an error");
   property p_bus_ans;
      $rose(read) |-> waitrequest ##1 !waitrequest;
   endproperty
   a_bus_ans: assert property (p_bus_ans)
      else $error("register read not answered after one wait");
   // Main scenarios reached
   c_mc_deliver: cover property (@(posedge clk) take && accept != '0);
   c_blocked: cover property (@(posedge clk) take && blocked);
   c_silent: cover property (@(posedge clk) mc_silent_discard);
   c_uc_stall: cover property (@(posedge clk) uc_valid && !uc_ready);
endmodule

// *** verif/mcr_sink.sv ***
// Far-side model: egress stages and ordinary routing taking offered TLPs.
// Assumes the route block holds valid and payload until ready is seen.
`timescale 1ns/1ps
module mcr_sink #(
   parameter int NPORTS = 4
) (
   // Clock and back-pressure control
   input wire logic clk,
   input wire logic stall,
   // Acceptance toward the route block
   output logic [NPORTS-1:0] eg_ready,
   output logic uc_ready
);
   // Ready changes just after each edge; stalls test held offers
   initial begin
      eg_ready = '0;
      uc_ready = 1'b0;
      forever begin
         @(posedge clk);
         eg_ready <= stall ? NPORTS'($urandom) : '1;
         uc_ready <= stall ? 1'($urandom) : 1'b1;
      end
   end
endmodule

// *** verif/test_multicast_tlp_classify_route.sv ***
// Random self-checking bench for the multicast classify and route block.
// Assumes the design sources and the sink model are compiled first.
`timescale 1ns/1ps
`include "mcr_defines.svh"
module test_multicast_tlp_classify_route;
   import mcr_pkg::*;
   logic clk, reset_n, read, write, waitrequest, in_valid, in_ready;
   logic in_srcval_fail, uc_valid, uc_ready, stall, en;
   logic credit_return, aer_mc_blocked, acs_src_violation;
   logic mc_silent_discard;
   logic [11:0] address;
   logic [31:0] writedata, readdata, q, eg_tag;
   logic [1:0] in_port, in_at, uc_port;
   mcr_tlp_kind_t in_kind;
   logic [63:0] in_addr, uc_addr, base;
   logic [7:0] in_tag, uc_tag;
   logic [3:0] eg_valid, eg_ready, fn_en;
   logic [23:0] eg_gid;
   logic [255:0] eg_addr;
   logic [63:0] rcv [4], blk [4], blu [4];
   logic [5:0] idx, cnt;
   int errors, comparisons;

   mcr_route i_mcr_route (.clk, .reset_n, .address, .read, .write,
      .writedata, .readdata, .waitrequest, .in_valid, .in_ready, .in_port,
      .in_kind, .in_addr, .in_at, .in_tag, .in_srcval_fail, .uc_valid,
      .uc_ready, .uc_port, .uc_addr, .uc_tag, .eg_valid, .eg_ready, .eg_gid,
      .eg_addr, .eg_tag, .credit_return, .aer_mc_blocked,
      .acs_src_violation, .mc_silent_discard);
   mcr_sink i_mcr_sink (.clk, .stall, .eg_ready, .uc_ready);

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic test_done();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [63:0] e, g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   // One Avalon cycle; held until waitrequest is seen low
   task automatic bus(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      @(posedge clk);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (waitrequest !== 1'b0) begin
         errors++;
         test_done();
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   function automatic logic [11:0] pa(input logic [1:0] p, input [3:0] r);
      return {4'h1, p, r, 2'b00};
   endfunction

   // Program identical routing fields and random per-port vectors
   task automatic cfg(input logic e, input logic [5:0] c, i);
      logic [223:0] v;
      en = e;
      cnt = c;
      idx = i;
      base = {$urandom, $urandom} >> (i + 6) << (i + 6);
      bus(1, `MCR_OFS_CTRL, {18'h0, c, 7'h0, e});
      bus(1, `MCR_OFS_BASE_LO, base[31:0] | 32'(i));
      bus(1, `MCR_OFS_BASE_HI, base[63:32]);
      for (int p = 0; p < 4; p++) begin
         fn_en[p] = 1'($urandom);
         rcv[p] = {$urandom, $urandom};
         blk[p] = {$urandom, $urandom} & {$urandom, $urandom} & rcv[p];
         blu[p] = {$urandom, $urandom} & {$urandom, $urandom};
         v = {blu[p], blk[p], rcv[p], 31'h0, fn_en[p]};
         for (int r = 0; r < 7; r++) bus(1, pa(p, 4'(r)), v[r*32+:32]);
      end
   endtask

   // Offer one header, then check the answer in the following cycle
   task automatic send(input logic [1:0] p, input mcr_tlp_kind_t k,
         input logic [63:0] a, input logic [1:0] at, input logic sv);
      int b, n;
      logic [5:0] g;
      logic [7:0] t;
      logic mc, bl;
      logic [3:0] acc;
      b = $clog2(int'(cnt) + 1);
      g = 6'((a >> idx) & ((64'h1 << b) - 1));
      mc = en && k != MCR_TLP_OTHER && g <= cnt &&
         (a >> (idx + b)) == (base >> (idx + b));
      bl = mc && !sv && (blk[p][g] || (blu[p][g] && at == 2'h0));
      for (int f = 0; f < 4; f++)
         acc[f] = mc && !sv && !bl && f != p && fn_en[f] && rcv[f][g];
      t = 8'($urandom);
      @(posedge clk);
      in_valid <= 1'b1;
      in_port <= p;
      in_kind <= k;
      in_addr <= a;
      in_at <= at;
      in_tag <= t;
      in_srcval_fail <= sv;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (in_ready !== 1'b1 && n < 50);
      if (in_ready !== 1'b1) begin
         errors++;
         test_done();
      end
      in_valid <= 1'b0;
      #1;
      chk("uc_valid", !mc, uc_valid);
      if (!mc) chk("uc_addr", a, uc_addr);
      if (!mc) chk("uc_port", p, uc_port);
      if (!mc) chk("uc_tag", t, uc_tag);
      chk("eg_valid", acc, eg_valid);
      chk("credit", mc && (sv || bl), credit_return);
      chk("aer", bl, aer_mc_blocked);
      chk("acs", mc && sv, acs_src_violation);
      chk("silent", mc && !sv && !bl && !acc, mc_silent_discard);
      for (int f = 0; f < 4; f++) begin
         if (acc[f]) chk("eg_gid", g, eg_gid[f*6+:6]);
         if (acc[f]) chk("eg_tag", t, eg_tag[f*8+:8]);
         if (acc[f]) chk("eg_addr", a, eg_addr[f*64+:64]);
      end
      n = 0;
      while ((eg_valid | uc_valid) !== 0 && n < 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 50) begin
         errors++;
         test_done();
      end
      if (bl) begin
         bus(0, `MCR_OFS_LOG_LO, 0);
         chk("log_lo", a[31:0], q);
         bus(0, `MCR_OFS_LOG_INFO, 0);
         chk("log_info", {p, g}, q);
         bus(0, pa(p, `MCR_PREG_STATUS), 0);
         chk("status", p == 0 ? 1 : 2, q);
         bus(1, pa(p, `MCR_PREG_STATUS), 32'h3);
      end
   endtask

   // Main sequence; fourth round each time runs with multicast off
   initial begin
      logic [63:0] a;
      int gi;
      {reset_n, read, write, in_valid, in_srcval_fail, stall} = '0;
      {address, writedata, in_port, in_addr, in_at, in_tag} = '0;
      in_kind = MCR_TLP_MWR;
      errors = 0;
      comparisons = 0;
      void'($urandom(32'hafee));
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      bus(0, `MCR_OFS_CAP, 0);
      chk("cap", `MCR_CAP_LIMIT_RST, q);
      bus(0, 12'h0fc, 0);
      chk("unmapped", 0, q);
      for (int r = 0; r < 12; r++) begin
         cfg(r % 4 != 3, r == 0 ? 6'h0 : r == 1 ? 6'h3f : 6'($urandom),
            6'(12 + $urandom % 29));
         stall = r[0];
         for (int i = 0; i < 40; i++) begin
            gi = $urandom % (int'(cnt) + 3);
            a = base + (64'(gi) << idx) +
               ({$urandom, $urandom} & ((64'h1 << idx) - 1));
            if ($urandom % 5 == 0) a = {$urandom, $urandom};
            send(2'($urandom), mcr_tlp_kind_t'($urandom % 3), a,
               2'($urandom), $urandom % 6 == 0);
         end
      end
      test_done();
   end
endmodule
